// ### core/eau_pkg.sv
package eau_pkg;
  // register port geometry
  localparam int unsigned EAU_AW = 3;
  localparam int unsigned EAU_DW = 8;
  // register indices on the plain port
  localparam logic [2:0] EAU_OFF_DATA_PAGE = 3'h0;
  localparam logic [2:0] EAU_OFF_EXTRA_PAGE = 3'h1;
  localparam logic [2:0] EAU_OFF_STACK_PAGE = 3'h2;
  localparam logic [2:0] EAU_OFF_CODE_PAGE = 3'h3;
  localparam logic [2:0] EAU_OFF_SHORT_BASE = 3'h4;
  localparam logic [2:0] EAU_OFF_CTRL = 3'h5;
  localparam logic [2:0] EAU_OFF_STATUS = 3'h6;
  // reset values
  localparam logic [7:0] EAU_PAGE_RST = 8'h00;
  localparam logic EAU_MINMODE_RST = 1'b0;
  // control register field
  localparam int unsigned EAU_CTRL_MIN_BIT = 0;
  // status register fields
  localparam int unsigned EAU_STAT_BUSY_BIT = 0;
  localparam int unsigned EAU_STAT_BAD_BIT = 1;
  localparam int unsigned EAU_STAT_WORD_BIT = 2;
  // effective address field layout
  localparam int unsigned EAU_SIZE_BIT = 3;
  localparam int unsigned EAU_SEL_LSB = 0;
  localparam int unsigned EAU_SEL_W = 3;
  // upper nibble codes of the register based and absolute modes
  localparam logic [3:0] EAU_NIB_REG_DIRECT = 4'hA;
  localparam logic [3:0] EAU_NIB_PRE_DEC = 4'hB;
  localparam logic [3:0] EAU_NIB_POST_INC = 4'hC;
  localparam logic [3:0] EAU_NIB_REG_IND = 4'hD;
  localparam logic [3:0] EAU_NIB_DISP8 = 4'hE;
  localparam logic [3:0] EAU_NIB_DISP16 = 4'hF;
  localparam logic [3:0] EAU_NIB_ABS8 = 4'h0;
  localparam logic [3:0] EAU_NIB_ABS16 = 4'h1;
  localparam logic [2:0] EAU_ABS_LOW = 3'h5;
  // whole-byte immediate codes
  localparam logic [7:0] EAU_FLD_IMM8 = 8'h04;
  localparam logic [7:0] EAU_FLD_IMM16 = 8'h0C;
  // register numbers that steer the page choice and step
  localparam logic [2:0] EAU_SEL_R3 = 3'h3;
  localparam logic [2:0] EAU_SEL_R5 = 3'h5;
  localparam logic [2:0] EAU_SEL_R7 = 3'h7;
  // adjustment steps
  localparam logic [15:0] EAU_STEP_BYTE = 16'h0001;
  localparam logic [15:0] EAU_STEP_WORD = 16'h0002;
  // page forced in short absolute and minimum mode
  localparam logic [7:0] EAU_PAGE_ZERO = 8'h00;

  // decoded addressing modes
  typedef enum logic [3:0] {
    EAU_M_REG_DIRECT, EAU_M_REG_IND, EAU_M_DISP8, EAU_M_DISP16,
    EAU_M_PRE_DEC, EAU_M_POST_INC, EAU_M_IMM8, EAU_M_IMM16,
    EAU_M_ABS8, EAU_M_ABS16, EAU_M_INVALID
  } eau_mode_e;

  // sequencing states
  typedef enum logic {EAU_S_IDLE, EAU_S_WAIT_EXEC} eau_state_e;
endpackage

// ### core/eau_effective_address_unit.sv
`timescale 1ns/1ps
// Notes on behaviour
// [RULE1] seven addressing modes are supported
// [RULE2] first six modes usable, size independent
// [RULE3] branch target pc plus displacement, code page
// [RULE4] mode comes from the field byte
// [RULE5] extension is displacement, immediate or address
// [RULE6] size bit clear byte, set word
// [RULE7] three-bit select picks r0 to r7
// [RULE8] register direct gives register contents
// [RULE9] page by register group for indirect modes
// [RULE10] minimum mode drops every page register
// [RULE11] pre-decrement adjusts before, new value used
// [RULE12] post-increment uses original, adjusts after
// [RULE13] step one for byte, two word
// [RULE14] r7 always steps by two
// [RULE15] short absolute page zero, long uses data page
// [RULE16] immediate operand straight from extension bytes
module eau_effective_address_unit (
  input wire logic core_clk,
  input wire logic rst_b,
  // register port
  input wire logic [eau_pkg::EAU_AW-1:0] reg_addr,
  input wire logic [eau_pkg::EAU_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [eau_pkg::EAU_DW-1:0] reg_rdata,
  // request from the decode sequencer
  input wire logic dec_req,
  output logic dec_ready,
  input wire logic [7:0] ea_field,
  input wire logic [15:0] ext_data,
  input wire logic rel_req,
  input wire logic rel_long,
  input wire logic [15:0] pc_in,
  input wire logic exec_done,
  // general register file ports
  output logic [2:0] gr_rd_sel,
  input wire logic [15:0] gr_rd_data,
  output logic gr_wr,
  output logic [2:0] gr_wr_sel,
  output logic [15:0] gr_wr_data,
  // result
  output logic res_valid,
  output logic res_is_operand,
  output logic [15:0] res_operand,
  output logic [23:0] res_addr,
  output logic res_word,
  output logic res_bad
);
  import eau_pkg::*;

  // software visible page and control state
  logic [7:0] data_page_reg;
  logic [7:0] extra_page_reg;
  logic [7:0] stack_page_reg;
  logic [7:0] code_page_reg;
  logic [7:0] short_base_reg;
  logic min_mode;
  // sequencing
  eau_state_e state;
  eau_state_e next_state;
  // pending post-increment write
  logic [2:0] pend_sel;
  logic [15:0] pend_val;
  // combinational decode results
  eau_mode_e mode;
  logic size_word;
  logic [2:0] sel;
  logic [15:0] step;
  logic [7:0] page;
  logic [15:0] next_addr16;
  logic [7:0] next_page;
  logic next_is_operand;
  logic [15:0] next_operand;
  logic take;
  logic take_rel;

  // field byte to mode, shared by decode and status
  function automatic eau_mode_e decode_mode(input logic [7:0] f);
    eau_mode_e m;
    m = EAU_M_INVALID;
    case (f[7:4])
      EAU_NIB_REG_DIRECT: m = EAU_M_REG_DIRECT;
      EAU_NIB_PRE_DEC: m = EAU_M_PRE_DEC;
      EAU_NIB_POST_INC: m = EAU_M_POST_INC;
      EAU_NIB_REG_IND: m = EAU_M_REG_IND;
      EAU_NIB_DISP8: m = EAU_M_DISP8;
      EAU_NIB_DISP16: m = EAU_M_DISP16;
      EAU_NIB_ABS8, EAU_NIB_ABS16: begin
        // immediate codes share upper nibble 0 with short absolute, so test whole byte first
        if (f == EAU_FLD_IMM8) begin
          m = EAU_M_IMM8;
        end else if (f == EAU_FLD_IMM16) begin
          m = EAU_M_IMM16;
        end else if (f[2:0] == EAU_ABS_LOW) begin
          m = (f[7:4] == EAU_NIB_ABS8) ? EAU_M_ABS8 : EAU_M_ABS16;
        end
      end
      default: m = EAU_M_INVALID;
    endcase
    return m;
  endfunction

  // register group to page register
  function automatic logic [7:0] group_page(input logic [2:0] s, input logic [7:0] data_pg,
                                            input logic [7:0] extra_pg, input logic [7:0] stack_pg);
    logic [7:0] p;
    p = stack_pg;
    if (s <= EAU_SEL_R3) begin
      p = data_pg;
    end else if (s <= EAU_SEL_R5) begin
      p = extra_pg;
    end
    return p;
  endfunction

  // field split
  // [RULE4] mode from field
  assign mode = decode_mode(ea_field);
  // [RULE6] size bit meaning
  assign size_word = ea_field[EAU_SIZE_BIT];
  // [RULE7] binary register select
  assign sel = ea_field[EAU_SEL_LSB +: EAU_SEL_W];
  assign gr_rd_sel = sel;
  assign dec_ready = (state == EAU_S_IDLE);
  // requests are ignored while a post-increment is still owed
  assign take = dec_req && dec_ready && !rel_req;
  assign take_rel = rel_req && dec_ready;

  // [RULE13] step by size
  // [RULE14] r7 keeps stack word aligned
  assign step = (size_word || sel == EAU_SEL_R7) ? EAU_STEP_WORD : EAU_STEP_BYTE;

  // [RULE9] page by register group
  assign page = group_page(sel, data_page_reg, extra_page_reg, stack_page_reg);

  // address and operand forming
  // [RULE1] all seven modes
  // [RULE2] size independent of mode
  always_comb begin
    next_addr16 = 16'h0000;
    next_page = EAU_PAGE_ZERO;
    next_is_operand = 1'b0;
    next_operand = 16'h0000;
    if (rel_req) begin
      // [RULE3] pc relative, code page
      next_page = code_page_reg;
      next_addr16 = rel_long ? (pc_in + ext_data) : (pc_in + {{8{ext_data[7]}}, ext_data[7:0]});
    end else begin
      case (mode)
        // [RULE8] operand is register
        EAU_M_REG_DIRECT: begin
          next_is_operand = 1'b1;
          next_operand = gr_rd_data;
        end
        EAU_M_REG_IND: begin
          next_page = page;
          next_addr16 = gr_rd_data;
        end
        // [RULE5] displacement, short one sign extended
        EAU_M_DISP8: begin
          next_page = page;
          next_addr16 = gr_rd_data + {{8{ext_data[7]}}, ext_data[7:0]};
        end
        EAU_M_DISP16: begin
          next_page = page;
          next_addr16 = gr_rd_data + ext_data;
        end
        // [RULE11] decremented value addresses
        EAU_M_PRE_DEC: begin
          next_page = page;
          next_addr16 = gr_rd_data - step;
        end
        // [RULE12] original value addresses
        EAU_M_POST_INC: begin
          next_page = page;
          next_addr16 = gr_rd_data;
        end
        // [RULE16] immediate from extension
        EAU_M_IMM8: begin
          next_is_operand = 1'b1;
          next_operand = {8'h00, ext_data[7:0]};
        end
        EAU_M_IMM16: begin
          next_is_operand = 1'b1;
          next_operand = ext_data;
        end
        // [RULE15] short absolute on page zero
        EAU_M_ABS8: begin
          next_page = EAU_PAGE_ZERO;
          next_addr16 = {short_base_reg, ext_data[7:0]};
        end
        EAU_M_ABS16: begin
          next_page = data_page_reg;
          next_addr16 = ext_data;
        end
        default: begin
          next_page = EAU_PAGE_ZERO;
        end
      endcase
    end
    // [RULE10] minimum mode drops pages
    if (min_mode) begin
      next_page = EAU_PAGE_ZERO;
    end
  end

  // result registers, one cycle after the request
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      res_valid <= 1'b0;
      res_is_operand <= 1'b0;
      res_operand <= 16'h0000;
      res_addr <= 24'h000000;
      res_word <= 1'b0;
      res_bad <= 1'b0;
    end else begin
      res_valid <= take || take_rel;
      if (take || take_rel) begin
        res_is_operand <= next_is_operand;
        res_operand <= next_operand;
        res_addr <= {next_page, next_addr16};
        res_word <= rel_req ? 1'b1 : size_word;
        res_bad <= !rel_req && (mode == EAU_M_INVALID);
      end
    end
  end

  // state machine: post-increment waits for execution to end
  always_comb begin
    next_state = state;
    case (state)
      EAU_S_IDLE: begin
        if (take && mode == EAU_M_POST_INC) begin
          next_state = EAU_S_WAIT_EXEC;
        end
      end
      EAU_S_WAIT_EXEC: begin
        if (exec_done) begin
          next_state = EAU_S_IDLE;
        end
      end
      default: next_state = EAU_S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= EAU_S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // pending increment captured at decode time
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_sel <= 3'h0;
      pend_val <= 16'h0000;
    end else if (take && mode == EAU_M_POST_INC) begin
      pend_sel <= sel;
      pend_val <= gr_rd_data + step;
    end
  end

  // register file write back
  // pre-decrement lands with the result; post-increment after exec_done
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      gr_wr <= 1'b0;
      gr_wr_sel <= 3'h0;
      gr_wr_data <= 16'h0000;
    end else begin
      gr_wr <= 1'b0;
      // [RULE11] decrement before execution
      if (take && mode == EAU_M_PRE_DEC) begin
        gr_wr <= 1'b1;
        gr_wr_sel <= sel;
        gr_wr_data <= next_addr16;
      // [RULE12] increment after execution
      end else if (state == EAU_S_WAIT_EXEC && exec_done) begin
        gr_wr <= 1'b1;
        gr_wr_sel <= pend_sel;
        gr_wr_data <= pend_val;
      end
    end
  end

  // software writes to page and control registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_page_reg <= EAU_PAGE_RST;
      extra_page_reg <= EAU_PAGE_RST;
      stack_page_reg <= EAU_PAGE_RST;
      code_page_reg <= EAU_PAGE_RST;
      short_base_reg <= EAU_PAGE_RST;
      min_mode <= EAU_MINMODE_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        EAU_OFF_DATA_PAGE: data_page_reg <= reg_wdata;
        EAU_OFF_EXTRA_PAGE: extra_page_reg <= reg_wdata;
        EAU_OFF_STACK_PAGE: stack_page_reg <= reg_wdata;
        EAU_OFF_CODE_PAGE: code_page_reg <= reg_wdata;
        EAU_OFF_SHORT_BASE: short_base_reg <= reg_wdata;
        EAU_OFF_CTRL: min_mode <= reg_wdata[EAU_CTRL_MIN_BIT];
        // status and unmapped writes are dropped
        default: ;
      endcase
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          EAU_OFF_DATA_PAGE: reg_rdata <= data_page_reg;
          EAU_OFF_EXTRA_PAGE: reg_rdata <= extra_page_reg;
          EAU_OFF_STACK_PAGE: reg_rdata <= stack_page_reg;
          EAU_OFF_CODE_PAGE: reg_rdata <= code_page_reg;
          EAU_OFF_SHORT_BASE: reg_rdata <= short_base_reg;
          EAU_OFF_CTRL: reg_rdata[EAU_CTRL_MIN_BIT] <= min_mode;
          EAU_OFF_STATUS: begin
            reg_rdata[EAU_STAT_BUSY_BIT] <= (state == EAU_S_WAIT_EXEC);
            reg_rdata[EAU_STAT_BAD_BIT] <= res_bad;
            reg_rdata[EAU_STAT_WORD_BIT] <= res_word;
          end
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_direct_operand: assert property ( // [RULE8]
    take && mode == EAU_M_REG_DIRECT |=> res_valid && res_is_operand && res_operand == $past(gr_rd_data))
    else $error("register direct operand wrong");
  a_imm_short_operand: assert property ( // [RULE16]
    take && mode == EAU_M_IMM8 |=> res_is_operand && res_operand == {8'h00, $past(ext_data[7:0])})
    else $error("short immediate operand wrong");
  a_predec_write: assert property ( // [RULE11]
    take && mode == EAU_M_PRE_DEC |=> gr_wr && gr_wr_data == res_addr[15:0])
    else $error("pre-decrement value not written");
  a_r7_step_two: assert property ( // [RULE14]
    take && mode == EAU_M_PRE_DEC && sel == EAU_SEL_R7 |=> gr_wr_data == $past(gr_rd_data) - EAU_STEP_WORD)
    else $error("r7 step not two");
  a_byte_step_one: assert property ( // [RULE13]
    take && mode == EAU_M_POST_INC && !size_word && sel != EAU_SEL_R7 |=> pend_val == $past(gr_rd_data) + 16'h0001)
    else $error("byte step not one");
  a_postinc_after_exec: assert property ( // [RULE12]
    (take && mode == EAU_M_POST_INC) || (state == EAU_S_WAIT_EXEC && !exec_done) |=> !gr_wr)
    else $error("post-increment written early");
  a_min_mode_page: assert property ( // [RULE10]
    min_mode && (take || take_rel) |=> res_addr[23:16] == EAU_PAGE_ZERO)
    else $error("page used in minimum mode");
  a_stack_page_group: assert property ( // [RULE9]
    !min_mode && take && mode == EAU_M_REG_IND && sel[2:1] == 2'h3 |=> res_addr[23:16] == $past(stack_page_reg))
    else $error("stack page not used for r6 r7");
  a_short_abs_addr: assert property ( // [RULE15]
    take && mode == EAU_M_ABS8 |=> res_addr == {EAU_PAGE_ZERO, $past(short_base_reg), $past(ext_data[7:0])})
    else $error("short absolute address wrong");
  a_rel_code_page: assert property ( // [RULE3]
    !min_mode && take_rel |=> res_addr[23:16] == $past(code_page_reg))
    else $error("branch target not on code page");
  c_postinc_cycle: cover property (take && mode == EAU_M_POST_INC ##[1:20] gr_wr);
  c_disp_word: cover property (take && mode == EAU_M_DISP16 && size_word);
  c_branch_short: cover property (take_rel && !rel_long);
endmodule

// ### verif/eau_regfile_model.sv
`timescale 1ns/1ps
// behavioural general register file on the far side of the address unit
module eau_regfile_model (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [2:0] rd_sel,
  output logic [15:0] rd_data,
  input wire logic wr,
  input wire logic [2:0] wr_sel,
  input wire logic [15:0] wr_data
);
  // eight 16-bit general registers
  logic [15:0] regs [8];

  // read is combinational, answered in the cycle of the select
  assign rd_data = regs[rd_sel];

  // seed pattern at reset, so every register has a distinct value
  // and a wrong register choice shows up in the address
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 8; i++) begin
        regs[i] <= {i[2:0], 13'h0ACE};
      end
    end else if (wr) begin
      // base register update from the pre/post adjustment
      regs[wr_sel] <= wr_data;
    end
  end
endmodule

// ### verif/eau_tb.sv
`timescale 1ns/1ps
module tb;
  import eau_pkg::*;
  // one decode case: inputs, then the result it should give
  typedef struct packed {
    logic [7:0] fld;
    logic [15:0] ext;
    logic isop;
    logic [15:0] oper;
    logic [23:0] addr;
    logic word;
    logic bad;
  } eau_row_s;
  logic core_clk, rst_b, reg_wr, reg_rd, dec_req, dec_ready, rel_req, rel_long, exec_done;
  logic [2:0] reg_addr, gr_rd_sel, gr_wr_sel;
  logic [7:0] reg_wdata, reg_rdata, ea_field;
  logic [15:0] ext_data, pc_in, gr_rd_data, gr_wr_data, res_operand;
  logic gr_wr, res_valid, res_is_operand, res_word, res_bad;
  logic [23:0] res_addr;
  int errors, n_checks;
  eau_row_s rows [16];

  eau_effective_address_unit dut_u (.core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .dec_req, .dec_ready, .ea_field, .ext_data, .rel_req, .rel_long, .pc_in,
    .exec_done, .gr_rd_sel, .gr_rd_data, .gr_wr, .gr_wr_sel, .gr_wr_data, .res_valid,
    .res_is_operand, .res_operand, .res_addr, .res_word, .res_bad);
  eau_regfile_model rf_u (.core_clk(core_clk), .rst_b(rst_b), .rd_sel(gr_rd_sel),
    .rd_data(gr_rd_data), .wr(gr_wr), .wr_sel(gr_wr_sel), .wr_data(gr_wr_data));

  // 40 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // one comparison, counted
  task chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // single place the run ends
  task wrap_up();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // one-cycle write strobe
  task reg_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // read data only stands in the cycle after the strobe
  task reg_check(input logic [2:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", 24'(exp), 24'(reg_rdata));
  endtask

  // request pulse; result is looked at in the cycle after acceptance
  task issue(input logic rel, input logic lng, input logic [7:0] f, input logic [15:0] e);
    @(posedge core_clk);
    dec_req <= 1'b1;
    rel_req <= rel;
    rel_long <= lng;
    ea_field <= f;
    ext_data <= e;
    @(posedge core_clk);
    dec_req <= 1'b0;
    rel_req <= 1'b0;
    #1;
    chk("res_valid", 24'h1, 24'(res_valid));
  endtask

  // register write-back of an adjusted base, seen in this cycle
  task wb_chk(input logic [2:0] sel, input logic [15:0] nv);
    chk("gr_wr", 24'h1, 24'(gr_wr));
    chk("gr_wr_sel", 24'(sel), 24'(gr_wr_sel));
    chk("gr_wr_data", 24'(nv), 24'(gr_wr_data));
  endtask

  // pre-decrement: new value is both address and write-back
  task predec(input logic [7:0] f, input logic [23:0] a);
    issue(1'b0, 1'b0, f, 16'h0000);
    chk("res_addr", a, res_addr);
    wb_chk(f[2:0], a[15:0]);
  endtask

  // post-increment: old value addresses, unit stays busy until executed
  task post_inc(input logic [7:0] f, input logic [23:0] a, input logic [15:0] nv);
    issue(1'b0, 1'b0, f, 16'h0000);
    chk("res_addr", a, res_addr);
    chk("dec_ready", 24'h0, 24'(dec_ready));
    reg_check(EAU_OFF_STATUS, 8'({f[3], 2'b01}));
    // a request while busy must vanish without a result
    @(posedge core_clk);
    dec_req <= 1'b1;
    @(posedge core_clk);
    dec_req <= 1'b0;
    #1;
    chk("res_valid", 24'h0, 24'(res_valid));
    @(posedge core_clk);
    exec_done <= 1'b1;
    @(posedge core_clk);
    exec_done <= 1'b0;
    #1;
    wb_chk(f[2:0], nv);
    // bounded wait for the unit to return to idle
    for (int k = 0; k < 8 && dec_ready !== 1'b1; k++) @(posedge core_clk);
    if (dec_ready !== 1'b1) begin
      errors++;
      $display("MISMATCH dec_ready expected 1 seen %b", dec_ready);
      wrap_up();
    end
  endtask

  initial begin
    rst_b = 1'b0;
    {reg_wr, reg_rd, dec_req, rel_req, rel_long, exec_done} = 6'h00;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    ea_field = 8'h00;
    ext_data = 16'h0000;
    pc_in = 16'h1000;
    errors = 0;
    n_checks = 0;
    // pages set below: data 11, extra 22, stack 33, code 44, short base 55
    rows[0] = '{8'hA5, 16'h0000, 1'b1, 16'hAACE, 24'h0, 1'b0, 1'b0};
    rows[1] = '{8'hAF, 16'h0000, 1'b1, 16'hEACE, 24'h0, 1'b1, 1'b0};
    rows[2] = '{8'hA8, 16'h0000, 1'b1, 16'h0ACE, 24'h0, 1'b1, 1'b0};
    rows[3] = '{8'hD3, 16'h0000, 1'b0, 16'h0, 24'h116ACE, 1'b0, 1'b0};
    rows[4] = '{8'hDC, 16'h0000, 1'b0, 16'h0, 24'h228ACE, 1'b1, 1'b0};
    rows[5] = '{8'hD6, 16'h0000, 1'b0, 16'h0, 24'h33CACE, 1'b0, 1'b0};
    // upper byte of a short displacement must be ignored
    rows[6] = '{8'hE5, 16'h3380, 1'b0, 16'h0, 24'h22AA4E, 1'b0, 1'b0};
    rows[7] = '{8'hE9, 16'h0010, 1'b0, 16'h0, 24'h112ADE, 1'b1, 1'b0};
    rows[8] = '{8'hF2, 16'h1234, 1'b0, 16'h0, 24'h115D02, 1'b0, 1'b0};
    rows[9] = '{8'hFF, 16'hF000, 1'b0, 16'h0, 24'h33DACE, 1'b1, 1'b0};
    rows[10] = '{8'h04, 16'h12AB, 1'b1, 16'h00AB, 24'h0, 1'b0, 1'b0};
    rows[11] = '{8'h0C, 16'hBEEF, 1'b1, 16'hBEEF, 24'h0, 1'b1, 1'b0};
    rows[12] = '{8'h05, 16'h1277, 1'b0, 16'h0, 24'h005577, 1'b0, 1'b0};
    rows[13] = '{8'h1D, 16'h4321, 1'b0, 16'h0, 24'h114321, 1'b1, 1'b0};
    rows[14] = '{8'h20, 16'h0000, 1'b0, 16'h0, 24'h0, 1'b0, 1'b1};
    rows[15] = '{8'h14, 16'h0000, 1'b0, 16'h0, 24'h0, 1'b0, 1'b1};
    repeat (10) @(posedge core_clk);
    // quiet outputs while reset is held
    chk("dec_ready", 24'h1, 24'(dec_ready));
    chk("res_valid", 24'h0, 24'(res_valid));
    rst_b <= 1'b1;
    reg_check(EAU_OFF_DATA_PAGE, EAU_PAGE_RST);
    reg_check(EAU_OFF_CTRL, 8'h00);
    for (int i = 0; i < 5; i++) reg_write(3'(i), 8'(8'h11 * (i + 1)));
    for (int i = 0; i < 5; i++) reg_check(3'(i), 8'(8'h11 * (i + 1)));
    // status is read only, index 7 is unmapped
    reg_write(EAU_OFF_STATUS, 8'hFF);
    reg_write(3'h7, 8'hFF);
    reg_check(EAU_OFF_STATUS, 8'h00);
    reg_check(3'h7, 8'h00);
    // table of modes that leave the registers untouched
    for (int i = 0; i < 16; i++) begin
      issue(1'b0, 1'b0, rows[i].fld, rows[i].ext);
      chk("res_bad", 24'(rows[i].bad), 24'(res_bad));
      chk("gr_wr", 24'h0, 24'(gr_wr));
      chk("gr_rd_sel", 24'(rows[i].fld[2:0]), 24'(gr_rd_sel));
      if (!rows[i].bad) begin
        chk("res_is_operand", 24'(rows[i].isop), 24'(res_is_operand));
        chk("res_word", 24'(rows[i].word), 24'(res_word));
        if (rows[i].isop) chk("res_operand", 24'(rows[i].oper), 24'(res_operand));
        else chk("res_addr", rows[i].addr, res_addr);
      end
    end
    // adjustment steps: byte 1, word 2, r7 always 2
    predec(8'hB1, 24'h112ACD);
    predec(8'hB9, 24'h112ACB);
    predec(8'hB7, 24'h33EACC);
    post_inc(8'hC7, 24'h33EACC, 16'hEACE);
    // minimum mode drops the page byte
    reg_write(EAU_OFF_CTRL, 8'h01);
    post_inc(8'hCC, 24'h008ACE, 16'h8AD0);
    issue(1'b0, 1'b0, 8'hD4, 16'h0000);
    chk("res_addr", 24'h008AD0, res_addr);
    reg_write(EAU_OFF_CTRL, 8'h00);
    issue(1'b0, 1'b0, 8'hD4, 16'h0000);
    chk("res_addr", 24'h228AD0, res_addr);
    // byte step on an ordinary register
    post_inc(8'hC2, 24'h114ACE, 16'h4ACF);
    // branch target, with a plain request raised at the same edge
    issue(1'b1, 1'b0, 8'hA5, 16'h12F0);
    chk("res_addr", 24'h440FF0, res_addr);
    chk("res_is_operand", 24'h0, 24'(res_is_operand));
    @(posedge core_clk);
    #1;
    chk("res_valid", 24'h0, 24'(res_valid));
    pc_in <= 16'h7FFE;
    issue(1'b1, 1'b1, 8'hA5, 16'h8000);
    chk("res_addr", 24'h44FFFE, res_addr);
    chk("res_word", 24'h1, 24'(res_word));
    // exec_done while idle must not write back
    @(posedge core_clk);
    exec_done <= 1'b1;
    @(posedge core_clk);
    exec_done <= 1'b0;
    #1;
    chk("gr_wr", 24'h0, 24'(gr_wr));
    // reset in mid-run drops an owed post-increment
    issue(1'b0, 1'b0, 8'hC0, 16'h0000);
    @(posedge core_clk);
    rst_b <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("dec_ready", 24'h1, 24'(dec_ready));
    chk("res_addr", 24'h0, res_addr);
    @(posedge core_clk);
    rst_b <= 1'b1;
    reg_check(EAU_OFF_STATUS, 8'h00);
    reg_check(EAU_OFF_CODE_PAGE, EAU_PAGE_RST);
    // registers and pages back at their reset values
    predec(8'hB0, 24'h000ACD);
    wrap_up();
  end
endmodule
